// File: acfg_bank.v
`include "acfg_regs.vh"

module acfg_bank (
  // sample clock and reset
  input wire clk,
  input wire sys_rst,
  // serial configuration pins
  input wire cfg_reset_pin,
  input wire cfg_sclk,
  input wire cfg_sen_n,
  input wire cfg_sdata,
  output reg cfg_sdout_q,
  // straps: [0] coding, [1] interface
  input wire [1:0] format_select_pin,
  input wire narrow_variant,
  // converter core
  input wire [13:0] core_sample,
  // capture side
  output reg [13:0] sample_data_q,
  output reg sample_data_oe_n_q,
  output reg forwarded_sample_clock_q,
  output reg forwarded_sample_clock_oe_n_q,
  // analog and pad controls
  output reg lvds_mode_q,
  output reg [1:0] rise_edge_position_q,
  output reg [1:0] fall_edge_position_q,
  output reg [1:0] forwarded_clock_drive_q,
  output reg [1:0] lvds_strength_q,
  output reg [5:0] lvds_swing_q,
  output reg core_power_down_q,
  output reg reference_power_down_q,
  output reg high_freq_boost_q
);

  // synchronised pins
  wire [6:0] pins_s;
  wire sclk_s;
  wire sen_n_s;
  wire sdata_s;
  wire rst_pin_s;
  wire [1:0] fmt_pin_s;
  wire narrow_s;

  acfg_sync #(
    .WIDTH(7)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({narrow_variant, format_select_pin, cfg_reset_pin, cfg_sdata, cfg_sen_n, cfg_sclk}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign sen_n_s = pins_s[1];
  assign sdata_s = pins_s[2];
  assign rst_pin_s = pins_s[3];
  assign fmt_pin_s = pins_s[5:4];
  assign narrow_s = pins_s[6];

  // register storage
  reg [7:0] control_q;
  reg [7:0] swing_q;
  reg [7:0] test_pattern_q;
  reg [7:0] lvds_drive_strength_q;
  reg [7:0] sample_format_control_q;
  reg [7:0] custom_pattern_high_q;
  reg [7:0] custom_pattern_low_q;
  reg [7:0] interface_and_rise_edge_q;
  reg [7:0] fall_edge_latency_standby_q;
  reg [7:0] power_down_swing_enable_q;
  reg [7:0] high_freq_performance_q;
  reg [7:0] offset_pedestal_setting_q;

  wire wr_stb;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire [7:0] rd_addr;
  wire sdout;
  reg [7:0] rd_data;

  function [7:0] read_mux;
    input [7:0] addr;
    begin
      case (addr)
        `ACFG_ADDR_CONTROL: read_mux = control_q;
        `ACFG_ADDR_SWING: read_mux = swing_q;
        `ACFG_ADDR_TEST_PATTERN: read_mux = test_pattern_q;
        `ACFG_ADDR_DRIVE: read_mux = lvds_drive_strength_q;
        `ACFG_ADDR_FORMAT: read_mux = sample_format_control_q;
        `ACFG_ADDR_CUSTOM_HI: read_mux = custom_pattern_high_q;
        `ACFG_ADDR_CUSTOM_LO: read_mux = custom_pattern_low_q;
        `ACFG_ADDR_INTERFACE: read_mux = interface_and_rise_edge_q;
        `ACFG_ADDR_FALL_LAT: read_mux = fall_edge_latency_standby_q;
        `ACFG_ADDR_POWER: read_mux = power_down_swing_enable_q;
        `ACFG_ADDR_HIGH_FREQ: read_mux = high_freq_performance_q;
        `ACFG_ADDR_PEDESTAL: read_mux = offset_pedestal_setting_q;
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  always @*
  begin
    rd_data = read_mux(rd_addr);
  end

  acfg_serial u_serial (
    .clk(clk),
    .sys_rst(sys_rst),
    .sclk_s(sclk_s),
    .sen_n_s(sen_n_s),
    .sdata_s(sdata_s),
    .readout_en(control_q[`ACFG_CTRL_READOUT]),
    .rd_data(rd_data),
    .cur_addr(rd_addr),
    .wr_stb_q(wr_stb),
    .wr_addr_q(wr_addr),
    .wr_data_q(wr_data),
    .sdout_q(sdout)
  );

  // software reset bit self-clears by wiping the whole bank
  wire sw_reset;
  wire bank_clear;
  // while reading back only the control register accepts writes
  wire wr_ok;

  assign sw_reset = wr_stb && (wr_addr == `ACFG_ADDR_CONTROL) && wr_data[`ACFG_CTRL_SWRESET];
  assign bank_clear = rst_pin_s | sw_reset;
  assign wr_ok = wr_stb && (!control_q[`ACFG_CTRL_READOUT] || wr_addr == `ACFG_ADDR_CONTROL);

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      control_q <= `ACFG_REG_RESET;
      swing_q <= `ACFG_REG_RESET;
      test_pattern_q <= `ACFG_REG_RESET;
      lvds_drive_strength_q <= `ACFG_REG_RESET;
      sample_format_control_q <= `ACFG_REG_RESET;
      custom_pattern_high_q <= `ACFG_REG_RESET;
      custom_pattern_low_q <= `ACFG_REG_RESET;
      interface_and_rise_edge_q <= `ACFG_REG_RESET;
      fall_edge_latency_standby_q <= `ACFG_REG_RESET;
      power_down_swing_enable_q <= `ACFG_REG_RESET;
      high_freq_performance_q <= `ACFG_REG_RESET;
      offset_pedestal_setting_q <= `ACFG_REG_RESET;
    end
    else if (bank_clear)
    begin
      control_q <= `ACFG_REG_RESET;
      swing_q <= `ACFG_REG_RESET;
      test_pattern_q <= `ACFG_REG_RESET;
      lvds_drive_strength_q <= `ACFG_REG_RESET;
      sample_format_control_q <= `ACFG_REG_RESET;
      custom_pattern_high_q <= `ACFG_REG_RESET;
      custom_pattern_low_q <= `ACFG_REG_RESET;
      interface_and_rise_edge_q <= `ACFG_REG_RESET;
      fall_edge_latency_standby_q <= `ACFG_REG_RESET;
      power_down_swing_enable_q <= `ACFG_REG_RESET;
      high_freq_performance_q <= `ACFG_REG_RESET;
      offset_pedestal_setting_q <= `ACFG_REG_RESET;
    end
    else if (wr_ok)
    begin
      case (wr_addr)
        `ACFG_ADDR_CONTROL: control_q <= {7'h00, wr_data[`ACFG_CTRL_READOUT]};
        `ACFG_ADDR_SWING: swing_q <= {wr_data[7:2], 2'h0};
        `ACFG_ADDR_TEST_PATTERN: test_pattern_q <= wr_data;
        `ACFG_ADDR_DRIVE: lvds_drive_strength_q <= {6'h00, wr_data[1:0]};
        `ACFG_ADDR_FORMAT: sample_format_control_q <= {wr_data[7:5], 5'h00};
        `ACFG_ADDR_CUSTOM_HI: custom_pattern_high_q <= wr_data;
        `ACFG_ADDR_CUSTOM_LO: custom_pattern_low_q <= {wr_data[7:2], 2'h0};
        `ACFG_ADDR_INTERFACE: interface_and_rise_edge_q <= wr_data;
        `ACFG_ADDR_FALL_LAT: fall_edge_latency_standby_q <= {wr_data[7:6], 2'h0, wr_data[3:2], 2'h0};
        `ACFG_ADDR_POWER: power_down_swing_enable_q <= {1'b0, wr_data[6], 1'b0, wr_data[4], 2'h0, wr_data[1:0]};
        `ACFG_ADDR_HIGH_FREQ: high_freq_performance_q <= {7'h00, wr_data[0]};
        `ACFG_ADDR_PEDESTAL: offset_pedestal_setting_q <= {wr_data[7:2], 2'h0};
        default: control_q <= control_q;
      endcase
    end
  end

  // decoded controls
  wire [2:0] pattern_sel;
  wire digital_path_enable;
  wire dc_cancel_enable;
  wire light_sleep;
  wire full_power_off;
  wire output_buffer_off;
  wire [13:0] custom_word;
  wire lvds_sel;
  wire twos_sel;

  assign pattern_sel = test_pattern_q[2:0];
  assign digital_path_enable = fall_edge_latency_standby_q[`ACFG_FL_DIGITAL];
  assign dc_cancel_enable = sample_format_control_q[`ACFG_FMT_DC_EN];
  assign light_sleep = fall_edge_latency_standby_q[`ACFG_FL_SLEEP];
  assign full_power_off = power_down_swing_enable_q[`ACFG_PWR_FULL_OFF];
  assign output_buffer_off = power_down_swing_enable_q[`ACFG_PWR_OBUF_OFF];
  assign custom_word = {custom_pattern_high_q, custom_pattern_low_q[7:2]};

  assign lvds_sel = (interface_and_rise_edge_q[7:6] == `ACFG_IF_LVDS) ? 1'b1 :
                    (interface_and_rise_edge_q[7:6] == `ACFG_IF_CMOS) ? 1'b0 : ~fmt_pin_s[1];
  assign twos_sel = (sample_format_control_q[7:6] == `ACFG_FMT_TWOS) ? 1'b1 :
                    (sample_format_control_q[7:6] == `ACFG_FMT_OFFSET) ? 1'b0 :
                    (sample_format_control_q[7:6] == `ACFG_FMT_PIN) ? fmt_pin_s[0] : 1'b0;

  // ramp generator
  reg [13:0] ramp_q;
  reg [1:0] prescale_q;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ramp_q <= 14'h0000;
      prescale_q <= 2'h0;
    end
    else if (pattern_sel != `ACFG_PAT_RAMP)
    begin
      ramp_q <= 14'h0000;
      prescale_q <= 2'h0;
    end
    else if (narrow_s)
    begin
      prescale_q <= prescale_q + 2'h1;
      if (prescale_q == `ACFG_NARROW_PRESCALE)
        ramp_q <= (ramp_q + 14'h0001) & `ACFG_MASK12;
    end
    else
    begin
      ramp_q <= ramp_q + 14'h0001;
    end
  end

  reg toggle_q;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      toggle_q <= 1'b0;
    else
      toggle_q <= ~toggle_q;
  end

  // offset correction: sign-driven estimate, slow on purpose so noise averages out
  reg [13:0] dc_est_q;
  reg [7:0] dc_div_q;
  wire [13:0] dc_target;
  wire [13:0] corrected;

  assign dc_target = `ACFG_MID_CODE + {{8{offset_pedestal_setting_q[7]}}, offset_pedestal_setting_q[7:2]};
  assign corrected = core_sample - dc_est_q;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dc_est_q <= 14'h0000;
      dc_div_q <= 8'h00;
    end
    else if (!(dc_cancel_enable && digital_path_enable))
    begin
      dc_est_q <= 14'h0000;
      dc_div_q <= 8'h00;
    end
    else
    begin
      dc_div_q <= dc_div_q + 8'h01;
      if (dc_div_q == `ACFG_DC_STEP_CYCLES)
      begin
        if ($signed(corrected - dc_target) > 0)
          dc_est_q <= dc_est_q + 14'h0001;
        else if ($signed(corrected - dc_target) < 0)
          dc_est_q <= dc_est_q - 14'h0001;
      end
    end
  end

  // source selection
  reg [13:0] word14;
  reg [13:0] word_out;

  always @*
  begin
    word14 = core_sample;
    if (digital_path_enable)
    begin
      case (pattern_sel)
        `ACFG_PAT_NORMAL: word14 = dc_cancel_enable ? corrected : core_sample;
        `ACFG_PAT_ZEROS: word14 = 14'h0000;
        `ACFG_PAT_ONES: word14 = 14'h3fff;
        `ACFG_PAT_TOGGLE: word14 = toggle_q ? ~`ACFG_TOGGLE_A14 : `ACFG_TOGGLE_A14;
        `ACFG_PAT_RAMP: word14 = ramp_q;
        `ACFG_PAT_CUSTOM: word14 = custom_word;
        default: word14 = core_sample;
      endcase
    end
    // conversions are offset binary; two's complement flips the msb
    if (twos_sel && (!digital_path_enable || pattern_sel == `ACFG_PAT_NORMAL))
      word14 = {~word14[13], word14[12:0]};
    word_out = word14;
    if (narrow_s)
    begin
      // narrow part uses bits 13 to 2
      word_out = {2'h0, word14[13:2]};
      if (digital_path_enable && pattern_sel == `ACFG_PAT_TOGGLE)
        word_out = toggle_q ? (~`ACFG_TOGGLE_A12 & `ACFG_MASK12) : `ACFG_TOGGLE_A12;
      if (digital_path_enable && pattern_sel == `ACFG_PAT_RAMP)
        word_out = ramp_q & `ACFG_MASK12;
    end
  end

  // output stage and decoded pad controls, all registered
  wire pads_off;
  assign pads_off = output_buffer_off | light_sleep | full_power_off;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sample_data_q <= 14'h0000;
      sample_data_oe_n_q <= 1'b1;
      forwarded_sample_clock_q <= 1'b0;
      forwarded_sample_clock_oe_n_q <= 1'b1;
      lvds_mode_q <= 1'b0;
      rise_edge_position_q <= 2'h0;
      fall_edge_position_q <= 2'h0;
      forwarded_clock_drive_q <= 2'h0;
      lvds_strength_q <= 2'h0;
      lvds_swing_q <= 6'h00;
      core_power_down_q <= 1'b0;
      reference_power_down_q <= 1'b0;
      high_freq_boost_q <= 1'b0;
      cfg_sdout_q <= 1'b0;
    end
    else
    begin
      sample_data_q <= pads_off ? 14'h0000 : word_out;
      sample_data_oe_n_q <= pads_off;
      // one forwarded edge per sample word
      forwarded_sample_clock_q <= pads_off ? 1'b0 : ~forwarded_sample_clock_q;
      forwarded_sample_clock_oe_n_q <= pads_off;
      lvds_mode_q <= lvds_sel;
      // rise enable; code meaning depends on lvds_mode
      rise_edge_position_q <= interface_and_rise_edge_q[`ACFG_IF_RISE_EN] ? interface_and_rise_edge_q[2:1] : 2'h0;
      // fall enable; code meaning depends on lvds_mode
      fall_edge_position_q <= interface_and_rise_edge_q[`ACFG_IF_FALL_EN] ? fall_edge_latency_standby_q[7:6] : 2'h0;
      forwarded_clock_drive_q <= interface_and_rise_edge_q[5:4];
      lvds_strength_q <= lvds_drive_strength_q[1:0];
      lvds_swing_q <= (power_down_swing_enable_q[1:0] == `ACFG_SWING_ON) ? swing_q[7:2] : 6'h00;
      core_power_down_q <= light_sleep | full_power_off;
      reference_power_down_q <= full_power_off;
      high_freq_boost_q <= high_freq_performance_q[0];
      cfg_sdout_q <= sdout;
    end
  end

endmodule

// File: acfg_regs.vh
`ifndef ACFG_REGS_VH
`define ACFG_REGS_VH
// register offsets on the serial configuration port
`define ACFG_ADDR_CONTROL 8'h00
`define ACFG_ADDR_SWING 8'h01
`define ACFG_ADDR_TEST_PATTERN 8'h25
`define ACFG_ADDR_DRIVE 8'h26
`define ACFG_ADDR_FORMAT 8'h3d
`define ACFG_ADDR_CUSTOM_HI 8'h3f
`define ACFG_ADDR_CUSTOM_LO 8'h40
`define ACFG_ADDR_INTERFACE 8'h41
`define ACFG_ADDR_FALL_LAT 8'h42
`define ACFG_ADDR_POWER 8'h43
`define ACFG_ADDR_HIGH_FREQ 8'h4a
`define ACFG_ADDR_PEDESTAL 8'hbf
`define ACFG_REG_RESET 8'h00
// test pattern codes
`define ACFG_PAT_NORMAL 3'h0
`define ACFG_PAT_ZEROS 3'h1
`define ACFG_PAT_ONES 3'h2
`define ACFG_PAT_TOGGLE 3'h3
`define ACFG_PAT_RAMP 3'h4
`define ACFG_PAT_CUSTOM 3'h5
// format and interface codes
`define ACFG_FMT_PIN 2'h0
`define ACFG_FMT_TWOS 2'h2
`define ACFG_FMT_OFFSET 2'h3
`define ACFG_IF_LVDS 2'h1
`define ACFG_IF_CMOS 2'h3
`define ACFG_SWING_ON 2'h3
// field positions
`define ACFG_CTRL_READOUT 0
`define ACFG_CTRL_SWRESET 1
`define ACFG_FMT_DC_EN 5
`define ACFG_IF_RISE_EN 3
`define ACFG_IF_FALL_EN 0
`define ACFG_FL_DIGITAL 3
`define ACFG_FL_SLEEP 2
`define ACFG_PWR_FULL_OFF 6
`define ACFG_PWR_OBUF_OFF 4
// datapath constants
`define ACFG_TOGGLE_A14 14'h1555
`define ACFG_TOGGLE_A12 14'h0555
`define ACFG_MASK12 14'h0fff
`define ACFG_MID_CODE 14'h2000
`define ACFG_NARROW_PRESCALE 2'h3
`define ACFG_DC_STEP_CYCLES 8'hff
`define ACFG_SPI_LAST_BIT 5'h0f
`define ACFG_SPI_ADDR_DONE 5'h07
`endif

// File: acfg_sync.v
// two-stage synchroniser for levels arriving from outside the clock domain
module acfg_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: acfg_serial.v
// serial configuration port: 8 address bits then 8 data bits, msb first
module acfg_serial (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // synchronised serial pins
  input wire sclk_s,
  input wire sen_n_s,
  input wire sdata_s,
  // register side
  input wire readout_en,
  input wire [7:0] rd_data,
  output wire [7:0] cur_addr,
  output reg wr_stb_q,
  output reg [7:0] wr_addr_q,
  output reg [7:0] wr_data_q,
  output reg sdout_q
);

  reg sclk_prev_q;
  reg [4:0] bit_cnt_q;
  reg [15:0] shift_q;
  reg [7:0] out_sh_q;
  reg load_q;
  wire sclk_rise;
  wire sclk_fall;

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign cur_addr = shift_q[7:0];

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      out_sh_q <= 8'h00;
      load_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      sdout_q <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      wr_stb_q <= 1'b0;
      load_q <= 1'b0;
      // address is complete one cycle after the eighth rise
      if (load_q)
        out_sh_q <= rd_data;
      if (sen_n_s)
        bit_cnt_q <= 5'h00;
      else if (sclk_rise)
      begin
        shift_q <= {shift_q[14:0], sdata_s};
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == `ACFG_SPI_ADDR_DONE)
          load_q <= 1'b1;
        if (bit_cnt_q == `ACFG_SPI_LAST_BIT)
        begin
          wr_stb_q <= 1'b1;
          wr_addr_q <= shift_q[14:7];
          wr_data_q <= {shift_q[6:0], sdata_s};
        end
      end
      else if (sclk_fall && readout_en && bit_cnt_q > `ACFG_SPI_ADDR_DONE)
      begin
        sdout_q <= out_sh_q[7];
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

endmodule

// File: acfg_capture_model.sv
module acfg_capture_model (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // pads from the block
  input wire [13:0] sample_data,
  input wire data_oe_n,
  input wire fwd_clk,
  input wire fwd_oe_n,
  // what the capture logic sees
  output logic [13:0] pad_data,
  output logic [31:0] word_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] last_q;
  logic seen_q;
  // floating pads
  // a released bus changes every cycle so a stale word is never mistaken for data
  assign pad_data = data_oe_n ? ~last_q : sample_data;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      last_q <= 14'h0000;
      seen_q <= 1'b0;
      word_count <= 32'h0;
    end
    else
    begin
      last_q <= pad_data;
      seen_q <= fwd_clk;
      // one word per forwarded clock edge
      if (!fwd_oe_n && fwd_clk != seen_q)
        word_count <= word_count + 32'h1;
    end
  end
endmodule

// File: acfg_bank_props.sv
module acfg_bank_props (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // watched ports
  input wire cfg_sen_n,
  input wire cfg_reset_pin,
  input wire narrow_variant,
  input wire [13:0] sample_data_q,
  input wire sample_data_oe_n_q,
  input wire forwarded_sample_clock_q,
  input wire forwarded_sample_clock_oe_n_q,
  input wire [1:0] rise_edge_position_q,
  input wire [1:0] fall_edge_position_q,
  input wire [5:0] lvds_swing_q,
  input wire core_power_down_q,
  input wire reference_power_down_q,
  input wire high_freq_boost_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence cfg_quiet;
    (cfg_sen_n && !cfg_reset_pin)[*8];
  endsequence
  sequence narrow_held;
    narrow_variant[*5];
  endsequence
  clk_runs_a:
    assert property (!forwarded_sample_clock_oe_n_q && $past(!forwarded_sample_clock_oe_n_q)
      |-> forwarded_sample_clock_q != $past(forwarded_sample_clock_q)) else $error("clock stalled");
  float_data_a:
    assert property (sample_data_oe_n_q |-> sample_data_q == 14'h0000) else $error("data while off");
  oe_pair_a:
    assert property (sample_data_oe_n_q == forwarded_sample_clock_oe_n_q) else $error("enables split");
  fwd_low_off_a:
    assert property (forwarded_sample_clock_oe_n_q |-> !forwarded_sample_clock_q) else $error("clock while off");
  ref_core_a:
    assert property (reference_power_down_q |-> core_power_down_q) else $error("core left on");
  sleep_pads_a:
    assert property (core_power_down_q && $past(core_power_down_q) |-> sample_data_oe_n_q)
      else $error("pads on in sleep");
  narrow_top_a:
    assert property (narrow_held |-> sample_data_q[13:12] == 2'h0) else $error("narrow top bits set");
  cfg_quiet_a:
    assert property (cfg_quiet |=> $stable({rise_edge_position_q, fall_edge_position_q, lvds_swing_q,
      high_freq_boost_q})) else $error("config moved without write");
endmodule

bind acfg_bank acfg_bank_props props (.clk(clk), .sys_rst(sys_rst), .cfg_sen_n(cfg_sen_n),
  .cfg_reset_pin(cfg_reset_pin), .narrow_variant(narrow_variant), .sample_data_q(sample_data_q),
  .sample_data_oe_n_q(sample_data_oe_n_q), .forwarded_sample_clock_q(forwarded_sample_clock_q),
  .forwarded_sample_clock_oe_n_q(forwarded_sample_clock_oe_n_q), .rise_edge_position_q(rise_edge_position_q),
  .fall_edge_position_q(fall_edge_position_q), .lvds_swing_q(lvds_swing_q),
  .core_power_down_q(core_power_down_q), .reference_power_down_q(reference_power_down_q),
  .high_freq_boost_q(high_freq_boost_q));

// File: tb_acfg_bank.sv
`include "acfg_regs.vh"

module tb_acfg_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, cfg_reset_pin = 0, cfg_sclk = 0, cfg_sen_n = 1, cfg_sdata = 0;
  logic narrow_variant = 0;
  logic [1:0] format_select_pin = 2'h0;
  logic [13:0] core_sample = 14'h1234;
  logic cfg_sdout_q, sample_data_oe_n_q, forwarded_sample_clock_q, forwarded_sample_clock_oe_n_q;
  logic lvds_mode_q, core_power_down_q, reference_power_down_q, high_freq_boost_q;
  logic [13:0] sample_data_q, pad_data, prev, mask;
  logic [1:0] rise_edge_position_q, fall_edge_position_q, forwarded_clock_drive_q, lvds_strength_q;
  logic [5:0] lvds_swing_q;
  logic [31:0] word_count;
  logic [7:0] rd;
  int n_errors = 0, compares = 0, cycles = 0;

  acfg_bank dut (.clk(clk), .sys_rst(sys_rst), .cfg_reset_pin(cfg_reset_pin), .cfg_sclk(cfg_sclk),
    .cfg_sen_n(cfg_sen_n), .cfg_sdata(cfg_sdata), .cfg_sdout_q(cfg_sdout_q), .format_select_pin(format_select_pin),
    .narrow_variant(narrow_variant), .core_sample(core_sample), .sample_data_q(sample_data_q),
    .sample_data_oe_n_q(sample_data_oe_n_q), .forwarded_sample_clock_q(forwarded_sample_clock_q),
    .forwarded_sample_clock_oe_n_q(forwarded_sample_clock_oe_n_q), .lvds_mode_q(lvds_mode_q),
    .rise_edge_position_q(rise_edge_position_q), .fall_edge_position_q(fall_edge_position_q),
    .forwarded_clock_drive_q(forwarded_clock_drive_q), .lvds_strength_q(lvds_strength_q),
    .lvds_swing_q(lvds_swing_q), .core_power_down_q(core_power_down_q),
    .reference_power_down_q(reference_power_down_q), .high_freq_boost_q(high_freq_boost_q));
  acfg_capture_model far_end (.clk(clk), .sys_rst(sys_rst), .sample_data(sample_data_q),
    .data_oe_n(sample_data_oe_n_q), .fwd_clk(forwarded_sample_clock_q),
    .fwd_oe_n(forwarded_sample_clock_oe_n_q), .pad_data(pad_data), .word_count(word_count));

  always #2 clk = ~clk;

  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 80000)
    begin
      n_errors = n_errors + 1;
      final_report();
    end
  end

  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask

  // address then data, msb first; read-back shifts in during the data half
  task automatic frame(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {a, d};
    cfg_sen_n = 0;
    for (int i = 0; i < 16; i++)
    begin
      cfg_sclk = 0;
      cfg_sdata = w[15 - i];
      ticks(8);
      if (i > 7)
        rd = {rd[6:0], cfg_sdout_q};
      cfg_sclk = 1;
      ticks(8);
    end
    cfg_sclk = 0;
    ticks(8);
    cfg_sen_n = 1;
    cfg_sdata = ~w[0];
    ticks(4);
  endtask

  task automatic reset_defaults;
    logic [7:0] adr [10] = '{`ACFG_ADDR_DRIVE, `ACFG_ADDR_FORMAT, `ACFG_ADDR_CUSTOM_HI, `ACFG_ADDR_CUSTOM_LO,
      `ACFG_ADDR_INTERFACE, `ACFG_ADDR_FALL_LAT, `ACFG_ADDR_POWER, `ACFG_ADDR_HIGH_FREQ, `ACFG_ADDR_PEDESTAL, 8'h55};
    check(pad_data, 14'h1234);
    check(lvds_mode_q, 14'h1);
    frame(`ACFG_ADDR_CONTROL, 8'h01);
    foreach (adr[i])
    begin
      frame(adr[i], 8'h00);
      check(rd, 8'h00);
    end
    frame(`ACFG_ADDR_CONTROL, 8'h00);
    frame(`ACFG_ADDR_HIGH_FREQ, 8'h01);
    frame(`ACFG_ADDR_DRIVE, 8'h03);
    check(high_freq_boost_q, 14'h1);
    check(lvds_strength_q, 14'h3);
    frame(`ACFG_ADDR_CONTROL, 8'h01);
    frame(`ACFG_ADDR_HIGH_FREQ, 8'h00);
    check(rd, 8'h01);
    frame(`ACFG_ADDR_CONTROL, 8'h00);
  endtask

  task automatic patterns;
    int k;
    frame(`ACFG_ADDR_TEST_PATTERN, {5'h0, `ACFG_PAT_ZEROS});
    check(pad_data, 14'h1234);
    frame(`ACFG_ADDR_FALL_LAT, 8'h08);
    frame(`ACFG_ADDR_CUSTOM_HI, 8'ha5);
    frame(`ACFG_ADDR_CUSTOM_LO, 8'hcc);
    for (int n = 0; n < 2; n++)
    begin
      narrow_variant = n[0];
      mask = n ? 14'h0fff : 14'h3fff;
      frame(`ACFG_ADDR_TEST_PATTERN, {5'h0, `ACFG_PAT_ZEROS});
      check(pad_data, 14'h0000);
      frame(`ACFG_ADDR_TEST_PATTERN, {5'h0, `ACFG_PAT_ONES});
      check(pad_data, mask);
      frame(`ACFG_ADDR_TEST_PATTERN, {5'h0, `ACFG_PAT_TOGGLE});
      prev = pad_data;
      ticks(1);
      check(pad_data ^ prev, mask);
      check(prev === (14'h1555 & mask) || prev === (14'h2aaa & mask), 14'h1);
      frame(`ACFG_ADDR_TEST_PATTERN, {5'h0, `ACFG_PAT_CUSTOM});
      check(pad_data, n ? 14'h0a5c : 14'h2973);
      frame(`ACFG_ADDR_TEST_PATTERN, {5'h0, `ACFG_PAT_RAMP});
      k = 0;
      while (pad_data !== mask && k < 17000)
      begin
        ticks(1);
        k++;
      end
      // top code then wrap to zero, then the first step up
      for (int r = 0; r < 2; r++)
      begin
        prev = pad_data;
        k = 0;
        while (pad_data === prev && k < 9)
        begin
          ticks(1);
          k++;
        end
        check(k[13:0], n ? 14'h4 : 14'h1);
        check(pad_data, (prev + 14'h1) & mask);
      end
    end
    narrow_variant = 0;
    frame(`ACFG_ADDR_TEST_PATTERN, {5'h0, `ACFG_PAT_NORMAL});
  endtask

  task automatic format_iface;
    core_sample = 14'h0123;
    frame(`ACFG_ADDR_FORMAT, {`ACFG_FMT_TWOS, 6'h0});
    check(pad_data, 14'h2123);
    frame(`ACFG_ADDR_FORMAT, {`ACFG_FMT_OFFSET, 6'h0});
    check(pad_data, 14'h0123);
    format_select_pin = 2'h3;
    frame(`ACFG_ADDR_FORMAT, {`ACFG_FMT_PIN, 6'h0});
    check(pad_data, 14'h2123);
    for (int c = 0; c < 4; c++)
    begin
      frame(`ACFG_ADDR_INTERFACE, {c[1:0], 6'h0});
      check(lvds_mode_q, c == 1);
    end
    format_select_pin = 2'h0;
    frame(`ACFG_ADDR_INTERFACE, 8'h4c);
    check({rise_edge_position_q, fall_edge_position_q}, 14'h8);
    frame(`ACFG_ADDR_FALL_LAT, 8'hc8);
    check(fall_edge_position_q, 14'h0);
    frame(`ACFG_ADDR_INTERFACE, 8'h75);
    check({forwarded_clock_drive_q, rise_edge_position_q, fall_edge_position_q}, 14'h33);
    // cmos interface with both edge controls on
    frame(`ACFG_ADDR_INTERFACE, 8'hcf);
    check({lvds_mode_q, rise_edge_position_q, fall_edge_position_q}, 14'hf);
  endtask

  task automatic power;
    logic [31:0] c;
    frame(`ACFG_ADDR_SWING, 8'hfc);
    // swing enable only ever 00 or 11
    frame(`ACFG_ADDR_POWER, 8'h00);
    check(lvds_swing_q, 14'h0);
    frame(`ACFG_ADDR_POWER, 8'h13);
    check(lvds_swing_q, 14'h3f);
    check({sample_data_oe_n_q, forwarded_sample_clock_oe_n_q, core_power_down_q}, 14'h6);
    c = word_count;
    ticks(5);
    check(word_count == c, 14'h1);
    frame(`ACFG_ADDR_POWER, 8'h40);
    check({core_power_down_q, reference_power_down_q, sample_data_oe_n_q}, 14'h7);
    frame(`ACFG_ADDR_POWER, 8'h00);
    frame(`ACFG_ADDR_FALL_LAT, 8'h0c);
    check({core_power_down_q, reference_power_down_q, sample_data_oe_n_q}, 14'h5);
    frame(`ACFG_ADDR_FALL_LAT, 8'h08);
    check({core_power_down_q, sample_data_oe_n_q}, 14'h0);
    frame(`ACFG_ADDR_CONTROL, 8'h02);
    check({high_freq_boost_q, rise_edge_position_q, lvds_strength_q}, 14'h0);
    frame(`ACFG_ADDR_HIGH_FREQ, 8'h01);
    cfg_reset_pin = 1;
    ticks(5);
    cfg_reset_pin = 0;
    check(high_freq_boost_q, 14'h0);
  endtask

  task automatic offset;
    core_sample = `ACFG_MID_CODE;
    frame(`ACFG_ADDR_FALL_LAT, 8'h08);
    frame(`ACFG_ADDR_PEDESTAL, 8'hf8);
    frame(`ACFG_ADDR_FORMAT, 8'h20);
    // two steps of the slow loop, with margin
    ticks(1200);
    check(pad_data, 14'h1ffe);
    frame(`ACFG_ADDR_FORMAT, 8'h00);
    check(pad_data, 14'h2000);
  endtask

  initial
  begin
    ticks(3);
    sys_rst = 0;
    ticks(4);
    reset_defaults();
    patterns();
    format_iface();
    power();
    offset();
    final_report();
  end
endmodule
